// file: synth_latch_program_powerdown.v
// latch bank, field decode and power-down sequencing of the synthesizer
//
// Behaviour
// - shift msb first, latch on strobe
// - select 00 loads control latch
// - main latch fields decoded
// - reference latch fields decoded
// - control load with CTL_PD_ARM clear powers device up
// - relock keeps band; main write while powered up reselects
// - prescaler bits select modulus
// - async mode powers down at once
// - sync mode waits two reference edges
// - chip enable low disables at once
// - powerdown resets counters, tristates outputs
// - serial register works during powerdown
// - pump current settings one and two
// - level bits select rf power
// - mute rf until locked
// - pump gain picks setting two or one
// - last pump gain write wins
// - tristate bit floats pump
// - polarity bit selects detector sense
// - counter reset holds counters
`timescale 1ns/1ps
`include "synth_latch_map.vh"
module synth_latch_program_powerdown #(
    parameter W = 24
) (
    input wire clk,
    input wire rst,
    input wire serial_clk,
    input wire serial_data,
    input wire load_strobe,
    input wire chip_enable,
    input wire ref_div_out,
    input wire lock_detect,
    input wire band_select_done,
    output reg [W-1:0] control_word_latch_q,
    output reg [W-1:0] main_divider_latch_q,
    output reg [W-1:0] reference_divider_latch_q,
    output reg [1:0] prescaler_ratio_q,
    output reg [2:0] pump_current_one_q,
    output reg [2:0] pump_current_two_q,
    output reg [2:0] pump_current_q,
    output reg pump_gain_select_q,
    output reg [1:0] rf_level_q,
    output reg detector_polarity_q,
    output reg [2:0] mux_select_q,
    output reg [1:0] core_level_q,
    output reg halved_prescaler_source_q,
    output reg output_halving_enable_q,
    output reg [12:0] main_count_field_q,
    output reg [4:0] swallow_count_field_q,
    output reg [1:0] band_clock_div_q,
    output reg factory_test_bit_q,
    output reg lock_count_precision_q,
    output reg [1:0] antibacklash_width_q,
    output reg [13:0] reference_count_field_q,
    output wire powered_down,
    output wire counters_load,
    output wire pump_tristate,
    output wire lock_detect_reset,
    output wire rf_output_enable,
    output wire ref_buffer_enable,
    output wire band_select_start,
    output wire bias_power_up
);
    localparam ST_OFF = 3'h1;
    localparam ST_ON = 3'h2;
    localparam ST_SYNC = 3'h4;

    wire [W-1:0] word;
    wire load_pulse;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] ref_edges_q;
    reg ref_q;
    reg band_start_q;
    reg band_valid_q;
    wire [1:0] sel;
    wire ld_ctl;
    wire ld_main;
    wire ld_ref;
    wire ref_rise;

    // shifter never gated by power state
    serial_word_shifter #(
        .W(W)
    ) u_shifter (
        .clk(clk),
        .rst(rst),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe),
        .word_q(word),
        .load_pulse_q(load_pulse)
    );

    assign sel = word[1:0];
    assign ld_ctl = load_pulse && (sel == `SEL_CONTROL);
    assign ld_main = load_pulse && (sel == `SEL_MAIN);
    assign ld_ref = load_pulse && (sel == `SEL_REFERENCE);
    assign ref_rise = ref_div_out && !ref_q;

    // latches load only on strobe pulse
    always @(posedge clk) begin
        if (rst) begin
            control_word_latch_q <= `LATCH_RESET;
        end else if (ld_ctl) begin
            control_word_latch_q <= word;
        end
    end

    // main latch on its own strobe
    always @(posedge clk) begin
        if (rst) begin
            main_divider_latch_q <= `LATCH_RESET;
        end else if (ld_main) begin
            main_divider_latch_q <= word;
        end
    end

    // reference latch on its own strobe
    always @(posedge clk) begin
        if (rst) begin
            reference_divider_latch_q <= `LATCH_RESET;
        end else if (ld_ref) begin
            reference_divider_latch_q <= word;
        end
    end

    // last write of gain wins
    // one strobe picks one latch, so both loads never coincide
    always @(posedge clk) begin
        if (rst) begin
            pump_gain_select_q <= 1'b0;
        end else if (ld_ctl) begin
            pump_gain_select_q <= word[`CTL_PUMP_GAIN];
        end else if (ld_main) begin
            pump_gain_select_q <= word[`MAIN_PUMP_GAIN];
        end
    end

    // field views of the latches
    wire [1:0] ctl_prescaler;
    wire [2:0] ctl_current_one;
    wire [2:0] ctl_current_two;
    wire [2:0] ctl_current_active;
    wire [1:0] ctl_rf_level;
    wire ctl_polarity;
    wire [2:0] ctl_mux;
    wire [1:0] ctl_core;
    wire main_halved_src;
    wire main_halving_en;
    wire [12:0] main_count;
    wire [4:0] main_swallow;
    wire [1:0] ref_band_div;
    wire ref_test;
    wire ref_precision;
    wire [1:0] ref_antibacklash;
    wire [13:0] ref_count;

    assign ctl_prescaler = control_word_latch_q[`CTL_PRESCALER_HI:`CTL_PRESCALER_LO];
    assign ctl_current_one = control_word_latch_q[`CTL_CP1_HI:`CTL_CP1_LO];
    assign ctl_current_two = control_word_latch_q[`CTL_CP2_HI:`CTL_CP2_LO];
    assign ctl_current_active = pump_gain_select_q ? ctl_current_two : ctl_current_one;
    assign ctl_rf_level = control_word_latch_q[`CTL_RF_LEVEL_HI:`CTL_RF_LEVEL_LO];
    assign ctl_polarity = control_word_latch_q[`CTL_POLARITY];
    assign ctl_mux = control_word_latch_q[`CTL_MUX_HI:`CTL_MUX_LO];
    assign ctl_core = control_word_latch_q[`CTL_CORE_HI:`CTL_CORE_LO];

    assign main_halved_src = main_divider_latch_q[`MAIN_HALVED_SRC];
    assign main_halving_en = main_divider_latch_q[`MAIN_HALVING_EN];
    assign main_count = main_divider_latch_q[`MAIN_B_HI:`MAIN_B_LO];
    assign main_swallow = main_divider_latch_q[`MAIN_A_HI:`MAIN_A_LO];

    assign ref_band_div = reference_divider_latch_q[`REF_BAND_HI:`REF_BAND_LO];
    assign ref_test = reference_divider_latch_q[`REF_TEST];
    assign ref_precision = reference_divider_latch_q[`REF_PRECISION];
    assign ref_antibacklash = reference_divider_latch_q[`REF_ABP_HI:`REF_ABP_LO];
    assign ref_count = reference_divider_latch_q[`REF_R_HI:`REF_R_LO];

    // control fields registered; one clk behind the latch
    always @(posedge clk) begin
        if (rst) begin
            prescaler_ratio_q <= 2'h0;
            pump_current_one_q <= 3'h0;
            pump_current_two_q <= 3'h0;
            pump_current_q <= 3'h0;
            rf_level_q <= 2'h0;
            detector_polarity_q <= 1'b0;
            mux_select_q <= 3'h0;
            core_level_q <= 2'h0;
        end else begin
            prescaler_ratio_q <= ctl_prescaler;
            pump_current_one_q <= ctl_current_one;
            pump_current_two_q <= ctl_current_two;
            pump_current_q <= ctl_current_active;
            rf_level_q <= ctl_rf_level;
            detector_polarity_q <= ctl_polarity;
            mux_select_q <= ctl_mux;
            core_level_q <= ctl_core;
        end
    end

    // main divider fields registered
    always @(posedge clk) begin
        if (rst) begin
            halved_prescaler_source_q <= 1'b0;
            output_halving_enable_q <= 1'b0;
            main_count_field_q <= 13'h0000;
            swallow_count_field_q <= 5'h00;
        end else begin
            halved_prescaler_source_q <= main_halved_src;
            output_halving_enable_q <= main_halving_en;
            main_count_field_q <= main_count;
            swallow_count_field_q <= main_swallow;
        end
    end

    // reference divider fields registered
    always @(posedge clk) begin
        if (rst) begin
            band_clock_div_q <= 2'h0;
            factory_test_bit_q <= 1'b0;
            lock_count_precision_q <= 1'b0;
            antibacklash_width_q <= 2'h0;
            reference_count_field_q <= 14'h0000;
        end else begin
            band_clock_div_q <= ref_band_div;
            factory_test_bit_q <= ref_test;
            lock_count_precision_q <= ref_precision;
            antibacklash_width_q <= ref_antibacklash;
            reference_count_field_q <= ref_count;
        end
    end

    // power state; a new control word always re-decides the mode
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (ld_ctl && !word[`CTL_PD_ARM]) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (ld_ctl && word[`CTL_PD_ARM]) begin
                    state_d = word[`CTL_PD_SYNC_MODE] ? ST_SYNC : ST_OFF;
                end
            end
            ST_SYNC: begin
                if (ld_ctl && !word[`CTL_PD_ARM]) begin
                    state_d = ST_ON;
                end else if (ld_ctl && !word[`CTL_PD_SYNC_MODE]) begin
                    state_d = ST_OFF;
                end else if (ref_rise && ref_edges_q == `SYNC_PD_EDGES - 2'h1) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // reference edge detector; idle level low matches reset
    always @(posedge clk) begin
        if (rst) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_div_out;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ref_edges_q <= 2'h0;
        end else if (state_q != ST_SYNC || ld_ctl) begin
            ref_edges_q <= 2'h0;
        end else if (ref_rise) begin
            ref_edges_q <= ref_edges_q + 2'h1;
        end
    end

    // band reselected only after main write
    // a relock after power-down reuses the band already chosen
    always @(posedge clk) begin
        if (rst) begin
            band_start_q <= 1'b0;
            band_valid_q <= 1'b0;
        end else begin
            band_start_q <= 1'b0;
            if (ld_main) begin
                band_valid_q <= 1'b0;
                band_start_q <= 1'b1;
            end else if (band_select_done) begin
                band_valid_q <= 1'b1;
            end
        end
    end

    assign powered_down = !chip_enable || (state_q == ST_OFF);
    assign bias_power_up = !powered_down;
    assign counters_load = powered_down || control_word_latch_q[`CTL_CNT_RESET];
    assign pump_tristate = powered_down || control_word_latch_q[`CTL_PUMP_TRI];
    assign lock_detect_reset = powered_down;
    assign ref_buffer_enable = !powered_down;
    assign rf_output_enable = !powered_down && (!control_word_latch_q[`CTL_MUTE] || lock_detect);
    assign band_select_start = band_start_q && !powered_down;
endmodule // synth_latch_program_powerdown

// file: synth_latch_map.vh
// offsets, field positions, reset values and timing counts of the synthesizer latch bank
`ifndef SYNTH_LATCH_MAP_VH
`define SYNTH_LATCH_MAP_VH
`define WORD_W 24
`define SEL_CONTROL 2'h0
`define SEL_REFERENCE 2'h1
`define SEL_MAIN 2'h2
`define SEL_TEST 2'h3
`define CTL_PRESCALER_HI 23
`define CTL_PRESCALER_LO 22
`define CTL_PD_SYNC_MODE 21
`define CTL_PD_ARM 20
`define CTL_CP2_HI 19
`define CTL_CP2_LO 17
`define CTL_CP1_HI 16
`define CTL_CP1_LO 14
`define CTL_RF_LEVEL_HI 13
`define CTL_RF_LEVEL_LO 12
`define CTL_MUTE 11
`define CTL_PUMP_GAIN 10
`define CTL_PUMP_TRI 9
`define CTL_POLARITY 8
`define CTL_MUX_HI 7
`define CTL_MUX_LO 5
`define CTL_CNT_RESET 4
`define CTL_CORE_HI 3
`define CTL_CORE_LO 2
`define MAIN_HALVED_SRC 23
`define MAIN_HALVING_EN 22
`define MAIN_PUMP_GAIN 21
`define MAIN_B_HI 20
`define MAIN_B_LO 8
`define MAIN_A_HI 6
`define MAIN_A_LO 2
`define REF_BAND_HI 21
`define REF_BAND_LO 20
`define REF_TEST 19
`define REF_PRECISION 18
`define REF_ABP_HI 17
`define REF_ABP_LO 16
`define REF_R_HI 15
`define REF_R_LO 2
`define LATCH_RESET 24'h000000
`define SYNC_PD_EDGES 2'h2
`endif

// file: serial_word_shifter.v
// 24-bit serial input shift register with edge-detected serial clock and load strobe
`timescale 1ns/1ps
module serial_word_shifter #(
    parameter W = 24
) (
    input wire clk,
    input wire rst,
    input wire serial_clk,
    input wire serial_data,
    input wire load_strobe,
    output reg [W-1:0] word_q,
    output reg load_pulse_q
);
    reg sclk_q;
    reg le_q;
    reg [W-1:0] shift_q;
    always @(posedge clk) begin
        if (rst) begin
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            shift_q <= {W{1'b0}};
            word_q <= {W{1'b0}};
            load_pulse_q <= 1'b0;
        end else begin
            sclk_q <= serial_clk;
            le_q <= load_strobe;
            // msb arrives first, so shift toward the top
            if (serial_clk && !sclk_q) begin
                shift_q <= {shift_q[W-2:0], serial_data};
            end
            load_pulse_q <= load_strobe && !le_q;
            if (load_strobe && !le_q) begin
                word_q <= shift_q;
            end
        end
    end
endmodule // serial_word_shifter

// file: serial_host.sv
// host model driving the three-wire serial link
`timescale 1ns/1ps
module serial_host (
    input wire clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk) serial_data = w[i];
            repeat (2) @(negedge clk);
            serial_clk = 1'b1;
            repeat (2) @(negedge clk);
            serial_clk = 1'b0;
        end
        // data hold over: show inverse, not last bit
        @(negedge clk) serial_data = ~w[0];
        load_strobe = 1'b1;
        repeat (3) @(negedge clk);
        load_strobe = 1'b0;
        repeat (2) @(negedge clk);
    endtask
endmodule // serial_host

// file: latch_bank_checker.sv
// concurrent checks on the synthesizer latch bank ports
`timescale 1ns/1ps
module latch_bank_checker #(
    parameter W = 24
) (
    input wire clk, input wire rst, input wire load_strobe, input wire chip_enable, input wire lock_detect,
    input wire [W-1:0] control_word_latch_q, input wire [W-1:0] main_divider_latch_q,
    input wire [W-1:0] reference_divider_latch_q, input wire [2:0] pump_current_one_q,
    input wire [2:0] pump_current_two_q, input wire [2:0] pump_current_q, input wire pump_gain_select_q,
    input wire [12:0] main_count_field_q, input wire [4:0] swallow_count_field_q,
    input wire [13:0] reference_count_field_q, input wire powered_down, input wire counters_load,
    input wire pump_tristate, input wire lock_detect_reset, input wire rf_output_enable, input wire ref_buffer_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_ce_disable: assert property (!chip_enable |-> powered_down)
        else $error("chip enable low while powered up");
    chk_pd_effects: assert property (powered_down |-> counters_load && pump_tristate && lock_detect_reset
        && !rf_output_enable && !ref_buffer_enable) else $error("power-down side effects missing");
    chk_latch_only_strobe: assert property ($changed({control_word_latch_q, main_divider_latch_q,
        reference_divider_latch_q}) |-> $past(load_strobe) || $past(load_strobe, 2) || $past(load_strobe, 3))
        else $error("latch changed without strobe");
    chk_main_decode: assert property ($changed(main_divider_latch_q) |=>
        main_count_field_q == $past(main_divider_latch_q[20:8]) && swallow_count_field_q == $past(main_divider_latch_q[6:2]))
        else $error("main latch fields wrong");
    chk_ref_decode: assert property ($changed(reference_divider_latch_q) |=>
        reference_count_field_q == $past(reference_divider_latch_q[15:2])) else $error("reference count wrong");
    chk_async_pd: assert property ($changed(control_word_latch_q) && control_word_latch_q[21:20] == 2'h1
        |-> ##[0:1] powered_down) else $error("async power-down late");
    chk_pump_pick: assert property (($stable(pump_gain_select_q) && $stable(pump_current_one_q)
        && $stable(pump_current_two_q))[*2] |-> pump_current_q == (pump_gain_select_q ? pump_current_two_q
        : pump_current_one_q)) else $error("pump current setting wrong");
    chk_mute_lock: assert property ((control_word_latch_q[11] && !lock_detect)[*3] |-> !rf_output_enable)
        else $error("rf on before lock");
    chk_cnt_reset: assert property (control_word_latch_q[4] [*2] |-> counters_load)
        else $error("counters not held");
    chk_pump_float: assert property (control_word_latch_q[9] [*2] |-> pump_tristate)
        else $error("pump not floated");
endmodule // latch_bank_checker

// file: synth_latch_program_powerdown_tb_top.sv
// self-checking bench for the synthesizer latch bank
`timescale 1ns/1ps
module synth_latch_program_powerdown_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chip_enable = 1'b1, ref_div_out = 1'b0, lock_detect = 1'b0, band_select_done = 1'b0;
    logic [31:0] lfsr = 32'h00ca;
    logic [23:0] exp_q[$];
    logic [23:0] prev_c, prev_m, prev_r, w;
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    wire serial_clk, serial_data, load_strobe, pgain, pdn, cload, ptri, rfen, bias;
    wire [23:0] ctl, mainl, refl;
    wire [2:0] pcur;
    wire [12:0] bcnt;
    always #4 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    serial_host host (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe));
    synth_latch_program_powerdown #(.W(24)) dut (.clk(clk), .rst(rst), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
        .lock_detect(lock_detect), .band_select_done(band_select_done), .control_word_latch_q(ctl),
        .main_divider_latch_q(mainl), .reference_divider_latch_q(refl), .prescaler_ratio_q(),
        .pump_current_one_q(), .pump_current_two_q(), .pump_current_q(pcur), .pump_gain_select_q(pgain),
        .rf_level_q(), .detector_polarity_q(), .mux_select_q(), .core_level_q(), .halved_prescaler_source_q(),
        .output_halving_enable_q(), .main_count_field_q(bcnt), .swallow_count_field_q(), .band_clock_div_q(),
        .factory_test_bit_q(), .lock_count_precision_q(), .antibacklash_width_q(), .reference_count_field_q(),
        .powered_down(pdn), .counters_load(cload), .pump_tristate(ptri), .lock_detect_reset(),
        .rf_output_enable(rfen), .ref_buffer_enable(), .band_select_start(), .bias_power_up(bias));
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic take(input logic [1:0] sel, input logic [23:0] val);
        logic [23:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~val;
        check({sel, val}, {e[1:0], e});
    endtask
    // monitor: every latch change must match the oldest pending write
    always @(posedge clk) begin
        if (!rst && ctl !== prev_c) take(2'h0, ctl);
        if (!rst && refl !== prev_r) take(2'h1, refl);
        if (!rst && mainl !== prev_m) take(2'h2, mainl);
        prev_c <= ctl;
        prev_r <= refl;
        prev_m <= mainl;
    end
    task automatic wr(input logic [23:0] v);
        if (v[1:0] != 2'h3) exp_q.push_back(v);
        host.send(v);
        repeat (3) @(negedge clk);
    endtask
    task automatic ref_pulse();
        @(negedge clk) ref_div_out = 1'b1;
        repeat (2) @(negedge clk);
        ref_div_out = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check(pdn, 1'b1);
        wr(24'h000065);
        wr(24'h0c4000);
        check({pdn, bias}, 2'b01);
        check(pcur, 3'h1);
        repeat (50) @(negedge clk);
        wr(24'h201902);
        band_select_done = 1'b1;
        check(bcnt, 13'h19);
        check({pgain, pcur}, 4'he);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            w = {lfsr[23:2], i[1:0]};
            if (i[1:0] == 2'h0) w[21:20] = 2'h0;
            wr(w);
        end
        wr(24'h1c4000);
        check({pdn, ptri, cload, rfen}, 4'he);
        // only the reference latch is touched while down
        wr(24'h000099);
        wr(24'h0c4000);
        check(pdn, 1'b0);
        wr(24'h3c4000);
        ref_pulse();
        check(pdn, 1'b0);
        ref_pulse();
        repeat (3) @(negedge clk);
        check(pdn, 1'b1);
        wr(24'h0c4800);
        check({pdn, rfen}, 2'b00);
        lock_detect = 1'b1;
        repeat (4) @(negedge clk);
        check(rfen, 1'b1);
        chip_enable = 1'b0;
        #1 check(pdn, 1'b1);
        @(negedge clk) chip_enable = 1'b1;
        wr(24'h0c4210);
        check({cload, ptri}, 2'b11);
        check(exp_q.size() == 0, 1'b1);
        tally_and_finish();
    end
endmodule // synth_latch_program_powerdown_tb_top
bind synth_latch_program_powerdown latch_bank_checker #(.W(W)) chk (.*);
